// *** hdl/sar_adc_pkg.sv ***
package sar_adc_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CHAN_SEL  = 3'h0;
    localparam logic [2:0] OFS_RES_HIGH  = 3'h1;
    localparam logic [2:0] OFS_RES_LOW   = 3'h2;
    localparam logic [2:0] OFS_RATE_CTRL = 3'h3;
    localparam logic [2:0] OFS_INT_STAT  = 3'h4;
    localparam logic [2:0] OFS_INT_MASK  = 3'h5;

    // Field positions in the channel select register
    localparam int BIT_READY  = 7;
    localparam int BIT_TOKEN  = 6;
    localparam int CODE_MSB   = 4;

    // Interrupt status bit positions
    localparam int INT_DONE   = 0;
    localparam int INT_REFUSE = 1;
    localparam int INT_TOKEN  = 2;
    localparam logic [7:0] INT_USED_MASK = 8'h07;

    // Reset values
    localparam logic [7:0] RST_CHAN_SEL = 8'h00;
    localparam logic [7:0] RST_RESULT   = 8'h00;
    localparam logic [7:0] RST_RATE     = 8'h00;
    localparam logic [7:0] RST_INT      = 8'h00;

    // Channel codes: zero disables, one reserved, 2..16 are port pins
    localparam logic [4:0] CODE_FIRST_PIN = 5'h02;
    localparam logic [4:0] CODE_LAST_PIN  = 5'h10;

    // Conversion clock rates selected by the rate field
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int RATE0_HZ   = 256_000;
    localparam int RATE1_HZ   = 128_000;
    localparam int RATE2_HZ   = 64_000;
    localparam int RATE3_HZ   = 32_000;
    localparam int DIV0_CYC   = SYS_CLK_HZ / RATE0_HZ;
    localparam int DIV1_CYC   = SYS_CLK_HZ / RATE1_HZ;
    localparam int DIV2_CYC   = SYS_CLK_HZ / RATE2_HZ;
    localparam int DIV3_CYC   = SYS_CLK_HZ / RATE3_HZ;

    // Conversion clocks spent sampling before the bit trials
    localparam int SAMPLE_TICKS = 2;

    // Request to the analog multiplexer and comparator core
    typedef struct packed {
        logic       sample;
        logic [4:0] channel;
        logic [9:0] trial;
    } analog_req_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_TRIAL  = 3'b010,
        ST_DECIDE = 3'b011,
        ST_LOAD   = 3'b100,
        ST_FINISH = 3'b101
    } conv_state_t;

endpackage : sar_adc_pkg

// *** hdl/sar_adc_control.sv ***
`timescale 1ns/1ps

// Operation
// - Convert the selected input by successive approximation into ten bits.
// - Decode 5-bit channel code; zero disables, one reserved, 2..16 pins.
// - Only a pin channel code may start a conversion.
// - Bit 7 clears only after the result sits in the data registers.
// - Bit 6 sets whenever a USB transaction is received or sent.
// - High data register holds result bits 9 down to 2.
// - Low register holds bits 1,0 in bits 7,6; rest read zero.
// - Zero to reference maps onto 1024 codes, left justified.
// - Rate field picks 256, 128, 64 or 32 kHz conversion clock.
// - Four conversion rates, nominally 20K down to 2.5K per second.
// - Channel select register resets to all zeros.
module sar_adc_control (
    input  wire logic                     ref_clk_in,
    input  wire logic                     rstn_in,
    input  wire logic [2:0]               addr_in,
    input  wire logic [7:0]               wr_data_in,
    input  wire logic                     wr_en_in,
    input  wire logic                     rd_en_in,
    input  wire logic                     usb_token_in,
    input  wire logic                     cmp_in,
    output logic [7:0]                    rd_data_out,
    output logic                          irq_out,
    output sar_adc_pkg::analog_req_t      analog_out
);
    import sar_adc_pkg::*;

    logic [7:0]  chan_sel_ff;
    logic [7:0]  res_high_ff;
    logic [7:0]  res_low_ff;
    logic [1:0]  rate_ff;
    logic [7:0]  int_stat_ff;
    logic [7:0]  int_mask_ff;
    logic [7:0]  nxt_rd_data;
    logic        cmp_meta_ff;
    logic        cmp_sync_ff;
    logic [8:0]  div_cnt_ff;
    logic        tick_ff;
    conv_state_t state_ff;
    conv_state_t nxt_state;
    logic [9:0]  sar_ff;
    logic [3:0]  bit_idx_ff;
    logic [1:0]  samp_cnt_ff;
    logic [4:0]  conv_chan_ff;
    logic        wr_chan;
    logic        start_req;
    logic        start_ok;
    logic        done_evt;
    logic        refuse_evt;
    logic [7:0]  int_set;

    // Legal pin channel code check
    function automatic logic code_valid(input logic [4:0] code);
        code_valid = (code >= CODE_FIRST_PIN) && (code <= CODE_LAST_PIN);
    endfunction : code_valid

    // Divider reload for each rate field setting
    function automatic logic [8:0] rate_div(input logic [1:0] sel);
        case (sel)
            2'b00:   rate_div = 9'(DIV0_CYC - 1);
            2'b01:   rate_div = 9'(DIV1_CYC - 1);
            2'b10:   rate_div = 9'(DIV2_CYC - 1);
            default: rate_div = 9'(DIV3_CYC - 1);
        endcase
    endfunction : rate_div

    // Register write qualifiers
    assign wr_chan    = wr_en_in && (addr_in == OFS_CHAN_SEL);
    assign start_req  = wr_chan && wr_data_in[BIT_READY]
                        && !chan_sel_ff[BIT_READY];
    assign start_ok   = start_req && code_valid(wr_data_in[CODE_MSB:0]);
    assign refuse_evt = start_req && !start_ok;
    assign done_evt   = (state_ff == ST_FINISH);
    assign int_set    = {5'h00, usb_token_in, refuse_evt, done_evt};

    // Comparator from the analog core is asynchronous
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cmp_meta_ff <= 1'b0;
            cmp_sync_ff <= 1'b0;
        end else begin
            cmp_meta_ff <= cmp_in;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            div_cnt_ff <= 9'h000;
            tick_ff    <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            div_cnt_ff <= rate_div(rate_ff);
            tick_ff    <= 1'b0;
        end else if (div_cnt_ff == 9'h000) begin
            div_cnt_ff <= rate_div(rate_ff);
            tick_ff    <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff - 9'h001;
            tick_ff    <= 1'b0;
        end
    end

    // Conversion sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tick_ff && (samp_cnt_ff == 2'(SAMPLE_TICKS - 1))) begin
                    nxt_state = ST_TRIAL;
                end
            end
            ST_TRIAL: begin
                if (tick_ff) begin
                    nxt_state = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if (bit_idx_ff == 4'h0) begin
                    nxt_state = ST_LOAD;
                end else begin
                    nxt_state = ST_TRIAL;
                end
            end
            ST_LOAD:   nxt_state = ST_FINISH;
            ST_FINISH: nxt_state = ST_IDLE;
            default:   nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Sample phase length counter
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            samp_cnt_ff <= 2'b00;
        end else if (state_ff != ST_SAMPLE) begin
            samp_cnt_ff <= 2'b00;
        end else if (tick_ff) begin
            samp_cnt_ff <= samp_cnt_ff + 2'b01;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            sar_ff     <= 10'h000;
            bit_idx_ff <= 4'h9;
        end else if (state_ff == ST_IDLE) begin
            sar_ff     <= 10'h000;
            bit_idx_ff <= 4'h9;
        end else if (state_ff == ST_DECIDE) begin
            sar_ff[bit_idx_ff] <= cmp_sync_ff;
            if (bit_idx_ff != 4'h0) begin
                bit_idx_ff <= bit_idx_ff - 4'h1;
            end
        end
    end

    // latch decoded channel for the mux
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            conv_chan_ff <= 5'h00;
        end else if (start_ok) begin
            conv_chan_ff <= wr_data_in[CODE_MSB:0];
        end
    end

    // Request to the analog core; trial bit set on top of kept bits
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            analog_out <= '0;
        end else begin
            analog_out.sample  <= (nxt_state == ST_SAMPLE);
            // Route the new code on the start edge, not the stale latch
            if (start_ok) begin
                analog_out.channel <= wr_data_in[CODE_MSB:0];
            end else if (nxt_state == ST_IDLE) begin
                analog_out.channel <= 5'h00;
            end else begin
                analog_out.channel <= conv_chan_ff;
            end
            if (state_ff == ST_TRIAL) begin
                analog_out.trial <= sar_ff | (10'h001 << bit_idx_ff);
            end else if (state_ff == ST_IDLE) begin
                analog_out.trial <= 10'h000;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            res_high_ff <= RST_RESULT;
            res_low_ff  <= RST_RESULT;
        end else if (state_ff == ST_LOAD) begin
            res_high_ff <= sar_ff[9:2];
            res_low_ff  <= {sar_ff[1:0], 6'h00};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            chan_sel_ff <= RST_CHAN_SEL;
        end else begin
            if (start_ok) begin
                chan_sel_ff[BIT_READY] <= 1'b1;
            end else if (done_evt) begin
                chan_sel_ff[BIT_READY] <= 1'b0;
            end
            if (usb_token_in) begin
                chan_sel_ff[BIT_TOKEN] <= 1'b1;
            end else if (wr_chan && !wr_data_in[BIT_TOKEN]) begin
                chan_sel_ff[BIT_TOKEN] <= 1'b0;
            end
            if (wr_chan && (chan_sel_ff[BIT_READY] == 1'b0)) begin
                chan_sel_ff[CODE_MSB:0] <= wr_data_in[CODE_MSB:0];
            end
            chan_sel_ff[5] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            rate_ff <= RST_RATE[1:0];
        end else if (wr_en_in && (addr_in == OFS_RATE_CTRL)) begin
            rate_ff <= wr_data_in[1:0];
        end
    end

    // Interrupt status: set wins over clear on read
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            int_stat_ff <= RST_INT;
        end else if (rd_en_in && (addr_in == OFS_INT_STAT)) begin
            int_stat_ff <= int_set;
        end else begin
            int_stat_ff <= int_stat_ff | int_set;
        end
    end

    // Interrupt mask and level output
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            int_mask_ff <= RST_INT;
            irq_out     <= 1'b0;
        end else begin
            if (wr_en_in && (addr_in == OFS_INT_MASK)) begin
                int_mask_ff <= wr_data_in & INT_USED_MASK;
            end
            irq_out <= |(int_stat_ff & int_mask_ff);
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        if (addr_in == OFS_CHAN_SEL) begin
            nxt_rd_data = chan_sel_ff;
        end else if (addr_in == OFS_RES_HIGH) begin
            nxt_rd_data = res_high_ff;
        end else if (addr_in == OFS_RES_LOW) begin
            nxt_rd_data = res_low_ff;
        end else if (addr_in == OFS_RATE_CTRL) begin
            nxt_rd_data = {6'h00, rate_ff};
        end else if (addr_in == OFS_INT_STAT) begin
            nxt_rd_data = int_stat_ff;
        end else if (addr_in == OFS_INT_MASK) begin
            nxt_rd_data = int_mask_ff;
        end else begin
            nxt_rd_data = 8'h00;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= nxt_rd_data;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

endmodule : sar_adc_control

// *** bench/sar_adc_checker.sv ***
`timescale 1ns/1ps
module sar_adc_checker (
    input wire logic                 ref_clk_in,
    input wire logic                 rstn_in,
    input wire logic [2:0]           addr_in,
    input wire logic [7:0]           wr_data_in,
    input wire logic                 wr_en_in,
    input wire logic                 rd_en_in,
    input wire logic                 usb_token_in,
    input wire logic                 cmp_in,
    input wire logic [7:0]           rd_data_out,
    input wire logic                 irq_out,
    input sar_adc_pkg::analog_req_t  analog_out
);
    import sar_adc_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // Start request with a pin channel or without one, while idle
    sequence start_ok_s;
        wr_en_in && addr_in == OFS_CHAN_SEL && wr_data_in[BIT_READY]
        && wr_data_in[4:0] >= CODE_FIRST_PIN
        && wr_data_in[4:0] <= CODE_LAST_PIN && analog_out.channel == 5'h00;
    endsequence
    sequence start_bad_s;
        wr_en_in && addr_in == OFS_CHAN_SEL && wr_data_in[BIT_READY]
        && (wr_data_in[4:0] < CODE_FIRST_PIN
        || wr_data_in[4:0] > CODE_LAST_PIN) && analog_out.channel == 5'h00;
    endsequence
    sequence sample_phase_s;
        analog_out.sample [*8];
    endsequence
    reset_clears_a: assert property (disable iff (1'b0)
        !rstn_in |=> rd_data_out == 8'h00 && !irq_out && analog_out == '0)
        else $error("outputs not cleared by reset");
    start_routes_a: assert property (
        start_ok_s |=> analog_out.channel == $past(wr_data_in[4:0]))
        else $error("channel code not routed");
    sample_hold_a: assert property (start_ok_s |=> sample_phase_s)
        else $error("sample phase too short");
    refuse_start_a: assert property (
        start_bad_s |=> !analog_out.sample [*8])
        else $error("conversion on bad channel");
    first_trial_a: assert property (
        $fell(analog_out.sample) && analog_out.channel != 5'h00
        |=> analog_out.trial == 10'h200)
        else $error("first trial not the top bit");
    idle_read_a: assert property (
        !rd_en_in || addr_in > OFS_INT_MASK |=> rd_data_out == 8'h00)
        else $error("read data outside a read");
    low_pad_a: assert property (
        rd_en_in && addr_in == OFS_RES_LOW |=> rd_data_out[5:0] == 6'h00)
        else $error("low result padding not zero");
    unused_bits_a: assert property (
        rd_en_in && addr_in == OFS_RATE_CTRL |=> rd_data_out[7:2] == 6'h00)
        else $error("rate spare bits not zero");
    chan_spare_a: assert property (
        rd_en_in && addr_in == OFS_CHAN_SEL |=> !rd_data_out[5])
        else $error("channel spare bit not zero");
    token_flag_a: assert property (
        usb_token_in ##[1:8] (rd_en_in && addr_in == OFS_CHAN_SEL)
        |=> rd_data_out[BIT_TOKEN])
        else $error("token flag missing");
    read_clear_a: assert property (
        rd_en_in && addr_in == OFS_INT_STAT && !usb_token_in
        && analog_out.channel == 5'h00 |-> ##2 !irq_out)
        else $error("status read did not drop irq");
endmodule : sar_adc_checker
bind sar_adc_control sar_adc_checker chk_u (.*);

// *** bench/sar_adc_model.sv ***
`timescale 1ns/1ps
module sar_adc_model (
    input wire logic                 ref_clk_in,
    input sar_adc_pkg::analog_req_t  analog_in,
    input wire logic [9:0]           level_in,
    output logic                     cmp_out
);
    import sar_adc_pkg::*;
    logic [9:0] held_ff;
    logic       cmp_ff;
    logic       tog_ff = 1'b0;
    // Hold: each channel shows the level XORed with its own code
    always_ff @(posedge ref_clk_in) begin
        if (analog_in.sample) begin
            held_ff <= level_in ^ {5'h00, analog_in.channel};
        end
        cmp_ff <= (held_ff >= analog_in.trial);
        tog_ff <= !tog_ff;
    end
    // Comparator output is meaningless while idle, so it wanders
    assign cmp_out = (analog_in.channel == 5'h00) ? tog_ff : cmp_ff;
endmodule : sar_adc_model

// *** bench/sar_adc_control_tb.sv ***
`timescale 1ns/1ps
module sar_adc_control_tb;
    import sar_adc_pkg::*;
    logic ref_clk_in = 0, rstn_in = 0, wr_en_in = 0, rd_en_in = 0;
    logic usb_token_in = 0, cmp_in, irq_out;
    logic [2:0] addr_in = 0;
    logic [7:0] wr_data_in = 0, rd_data_out;
    logic [9:0] level_in = 0;
    analog_req_t analog_out;
    int cyc = 0, mismatches = 0, n_tests = 0;
    sar_adc_control dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .usb_token_in(usb_token_in), .cmp_in(cmp_in),
        .rd_data_out(rd_data_out), .irq_out(irq_out),
        .analog_out(analog_out));
    sar_adc_model core_u (.ref_clk_in(ref_clk_in), .analog_in(analog_out),
        .level_in(level_in), .cmp_out(cmp_in));
    // Clock and cycle count
    always #50 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) cyc <= cyc + 1;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a; wr_data_in <= d; wr_en_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a; rd_en_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
    endtask : rd
    task automatic irq_after(input int n, input logic exp);
        repeat (n) @(posedge ref_clk_in);
        #1 chk(irq_out, exp);
    endtask : irq_after
    task automatic check_reset;
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d); chk(d, 8'h00);
        end
        wr(OFS_RATE_CTRL, 8'hff); rd(OFS_RATE_CTRL, d); chk(d, 8'h03);
        wr(OFS_CHAN_SEL, 8'h25); rd(OFS_CHAN_SEL, d); chk(d, 8'h05);
        wr(3'h6, 8'hff); wr(OFS_RES_HIGH, 8'haa);
        rd(3'h6, d); chk(d, 8'h00);
        rd(OFS_RES_HIGH, d); chk(d, 8'h00);
        wr(OFS_RATE_CTRL, 8'h00); wr(OFS_CHAN_SEL, 8'h00);
    endtask : check_reset
    task automatic refuse_bad;
        logic [7:0] d;
        logic [4:0] codes[4] = '{5'h00, 5'h01, 5'h11, 5'h1f};
        wr(OFS_INT_MASK, 8'h02);
        foreach (codes[i]) begin
            wr(OFS_CHAN_SEL, 8'h80 | {3'b000, codes[i]});
            rd(OFS_CHAN_SEL, d); chk(d[7], 1'b0);
            chk(irq_out, 1'b1);
            rd(OFS_INT_STAT, d); chk(d, 8'h02);
            irq_after(2, 1'b0);
        end
        wr(OFS_CHAN_SEL, 8'h00);
    endtask : refuse_bad
    task automatic token_seen;
        logic [7:0] d;
        wr(OFS_INT_MASK, 8'h00);
        @(posedge ref_clk_in) usb_token_in <= 1'b1;
        @(posedge ref_clk_in) usb_token_in <= 1'b0;
        irq_after(3, 1'b0);
        rd(OFS_CHAN_SEL, d); chk(d, 8'h40);
        wr(OFS_INT_MASK, 8'h04); irq_after(2, 1'b1);
        rd(OFS_INT_STAT, d); chk(d, 8'h04);
        irq_after(2, 1'b0);
        wr(OFS_CHAN_SEL, 8'h00); rd(OFS_CHAN_SEL, d); chk(d, 8'h00);
    endtask : token_seen
    task automatic convert(input logic [1:0] r, input logic [4:0] ch,
                           input logic [9:0] want);
        logic [7:0] d, hi_old;
        int t0, n, dv;
        dv = (r == 0) ? DIV0_CYC : (r == 1) ? DIV1_CYC
           : (r == 2) ? DIV2_CYC : DIV3_CYC;
        rd(OFS_RES_HIGH, hi_old);
        level_in <= want ^ {5'h00, ch};
        wr(OFS_RATE_CTRL, {6'h00, r}); wr(OFS_INT_MASK, 8'h01);
        wr(OFS_CHAN_SEL, 8'h80 | {3'b000, ch});
        t0 = cyc;
        rd(OFS_RES_HIGH, d); chk(d, hi_old);
        n = 0;
        do begin
            rd(OFS_CHAN_SEL, d); n++;
        end while (d[BIT_READY] && n < 3000);
        n = cyc - t0;
        chk(n >= 11 * dv && n <= 12 * dv + 40, 1'b1);
        rd(OFS_RES_HIGH, d); chk(d, want[9:2]);
        rd(OFS_RES_LOW, d); chk(d, {want[1:0], 6'h00});
        chk(irq_out, 1'b1);
        rd(OFS_INT_STAT, d); chk(d, 8'h01);
        irq_after(2, 1'b0);
    endtask : convert
    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        check_reset;
        refuse_bad;
        token_seen;
        convert(2'd0, 5'h02, 10'h3ff);
        convert(2'd1, 5'h07, 10'h000);
        convert(2'd2, 5'h0c, 10'h2a5);
        convert(2'd3, 5'h10, 10'h15a);
        tally_and_finish;
    end
    // Watchdog
    initial begin
        #(100 * 40000);
        mismatches++;
        tally_and_finish;
    end
endmodule : sar_adc_control_tb
